// ==== rtl/cfg_cmd_pkg.sv ====
// Constants for the configuration command handler
package cfg_cmd_pkg;
    // ****************************************
    // Message framing
    // ****************************************
    localparam logic [15:0] PROP_A_PGN = 16'hEF00;
    localparam logic [7:0] STATUS_PGN_UPPER = 8'hFF;
    localparam logic [7:0] KEEP_BYTE = 8'hFF;
    localparam logic [7:0] GRID_ADDR_ONLY = 8'h00;
    localparam logic [7:0] RESULT_FAIL = 8'h00;
    localparam logic [7:0] RESULT_OK = 8'h01;

    // ****************************************
    // Message identifiers
    // ****************************************
    localparam logic [7:0] ID_ACK = 8'h01;
    localparam logic [7:0] ID_SET_BASES = 8'h90;
    localparam logic [7:0] ID_POP_QUERY = 8'h92;
    localparam logic [7:0] ID_POP_SET = 8'h94;
    localparam logic [7:0] ID_DEF_SET = 8'h95;
    localparam logic [7:0] ID_DEF_QUERY = 8'h96;
    localparam logic [7:0] ID_SETTINGS = 8'h97;
    localparam logic [7:0] ID_DELAY_SET = 8'h99;

    // ****************************************
    // Status group number base and offsets
    // ****************************************
    localparam logic [7:0] PGN_BASE_RESET = 8'hA0;
    localparam logic [7:0] PGN_BASE_MAX = 8'hF1;
    localparam logic [7:0] OFS_FUSE = 8'h00;
    localparam logic [7:0] OFS_RELAY = 8'h01;
    localparam logic [7:0] OFS_ERROR = 8'h02;

    // ****************************************
    // Start-up delay
    // ****************************************
    localparam logic [15:0] DELAY_MS_RESET = 16'd1000;
    localparam logic [15:0] DELAY_MS_MAX = 16'hFFFE;
    localparam int CLK_MHZ = 125;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_MHZ * 1000000 / MS_PER_S;

    // ****************************************
    // Other reset values
    // ****************************************
    localparam logic [7:0] SA_BASE_RESET = 8'hB0;
    localparam logic RELAY_DEFAULT_RESET = 1'b0;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] REG_PGN_BASE = 8'h00;
    localparam logic [7:0] REG_SA_BASE = 8'h04;
    localparam logic [7:0] REG_DELAY = 8'h08;
    localparam logic [7:0] REG_POP_LO = 8'h0C;
    localparam logic [7:0] REG_POP_HI = 8'h10;
    localparam logic [7:0] REG_DEF_RELAY = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_MISSING_LO = 8'h1C;
    localparam logic [7:0] REG_MISSING_HI = 8'h20;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_CMD_CNT_LSB = 8;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : cfg_cmd_pkg

// ==== rtl/cfg_cmd_handler.sv ====
// Configuration command interpreter with AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Status group number upper byte always FF.
// - Lower byte is base plus type offset.
// - Base starts at A0 until changed.
// - Base accepts 00 through F1 only.
// - Fixed offsets: fuse 0, relay 1, error 2.
// - Query 97 replies 97, base in byte 7.
// - Command 90 byte 2 sets base; ack 01.
// - Byte 1 of 90 equal FF keeps address base.
// - Populated but absent component flags missing error.
// - Query 92 replies 94 with population bits.
// - Bad grid on population query: fail ack.
// - Command 94 writes population; ack 01.
// - Only factory positions may become populated.
// - Relays take stored defaults at power-up, breach.
// - Query 96 gives defaults bytes 4.0-5.4.
// - Command 95 sets default relay states; ack 01.
// - Ignore commands and send nothing during delay.
// - Delay is 16-bit ms, 0000 to FFFE.
// - Delay defaults to 1000 ms.
// - Reply 96 carries delay in bytes 6,7.
// - Command 99 bytes 1,2 set delay; ack 01.
// - Reply goes back to the commanding node.
// - Commands and replies use group EF00, ID first.
// - Byte 1 of 92, 94, 95, 96 is grid address, 00 only.
module cfg_cmd_handler #(
    parameter int NUM_COMP = 48,
    parameter int NUM_RELAY = 13,
    parameter logic [47:0] FACTORY_POP = 48'hFFFF_FFFF_FFFF,
    parameter int CYCLES_PER_MS = cfg_cmd_pkg::CYCLES_PER_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // Received command frames
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [15:0] cmd_pgn,
    input wire logic [7:0] cmd_src,
    input wire logic [63:0] cmd_data,
    // Reply frames
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [15:0] rsp_pgn,
    output logic [7:0] rsp_dest,
    output logic [63:0] rsp_data,
    // Surrounding system
    input wire logic [2:0] sa_offset,
    input wire logic [NUM_COMP-1:0] comp_present,
    input wire logic [NUM_RELAY-1:0] relay_state,
    input wire logic count_breach,
    output logic [15:0] fuse_status_pgn,
    output logic [15:0] relay_status_pgn,
    output logic [15:0] error_status_pgn,
    output logic [NUM_COMP-1:0] missing_comp,
    output logic [NUM_RELAY-1:0] relay_default,
    output logic relay_apply,
    output logic link_enable
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] msg_byte(input logic [63:0] d, input int idx);
        msg_byte = d[idx*8 +: 8];
    endfunction : msg_byte

    function automatic logic [63:0] ack_frame(input logic [7:0] id, input logic ok);
        ack_frame = {40'h00_0000_0000, (ok ? cfg_cmd_pkg::RESULT_OK : cfg_cmd_pkg::RESULT_FAIL), id,
                     cfg_cmd_pkg::ID_ACK};
    endfunction : ack_frame

    function automatic logic [15:0] status_pgn(input logic [7:0] base, input logic [7:0] ofs);
        status_pgn = {cfg_cmd_pkg::STATUS_PGN_UPPER, 8'(base + ofs)};
    endfunction : status_pgn

    // ****************************************
    // Settings storage
    // ****************************************
    logic [7:0] pgn_base_q;
    logic [7:0] sa_base_q;
    logic [15:0] delay_ms_q;
    logic [NUM_COMP-1:0] pop_q;
    logic [NUM_RELAY-1:0] def_relay_q;
    logic [15:0] cmd_cnt_q;

    // ****************************************
    // Start-up delay
    // ****************************************
    logic [31:0] tick_q;
    logic [15:0] ms_q;
    logic started_q;
    logic apply_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_q <= 32'h0000_0000;
            ms_q <= 16'h0000;
            started_q <= 1'b0;
        end else if (!started_q) begin
            if (ms_q >= delay_ms_q) begin
                started_q <= 1'b1;
            end else if (tick_q == 32'(CYCLES_PER_MS - 1)) begin
                tick_q <= 32'h0000_0000;
                ms_q <= ms_q + 16'h0001;
            end else begin
                tick_q <= tick_q + 32'h0000_0001;
            end
        end
    end

    // Defaults are pushed during reset and one cycle after every breach
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            apply_q <= 1'b1;
        end else begin
            apply_q <= count_breach;
        end
    end

    assign relay_apply = apply_q;
    assign relay_default = def_relay_q;
    assign link_enable = started_q;

    // ****************************************
    // Status group numbers and missing parts
    // ****************************************
    assign fuse_status_pgn = status_pgn(pgn_base_q, cfg_cmd_pkg::OFS_FUSE);
    assign relay_status_pgn = status_pgn(pgn_base_q, cfg_cmd_pkg::OFS_RELAY);
    assign error_status_pgn = status_pgn(pgn_base_q, cfg_cmd_pkg::OFS_ERROR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            missing_comp <= '0;
        end else begin
            missing_comp <= pop_q & ~comp_present;
        end
    end

    // ****************************************
    // Command decode
    // ****************************************
    logic take_cmd;
    logic [7:0] id_b;
    logic grid_ok;
    logic [NUM_COMP-1:0] pop_req;
    logic [NUM_RELAY-1:0] def_req;
    logic [15:0] delay_req;
    logic base_ok;
    logic pop_ok;
    logic delay_ok;
    logic known;

    assign cmd_ready = started_q && !rsp_valid;
    assign take_cmd = cmd_valid && cmd_ready;
    assign id_b = msg_byte(cmd_data, 0);
    assign grid_ok = msg_byte(cmd_data, 1) == cfg_cmd_pkg::GRID_ADDR_ONLY;
    assign pop_req = cmd_data[16 +: NUM_COMP];
    assign def_req = cmd_data[16 +: NUM_RELAY];
    assign delay_req = {msg_byte(cmd_data, 2), msg_byte(cmd_data, 1)};
    // Base request accepted only within range; 0xFF means leave it
    assign base_ok = msg_byte(cmd_data, 2) <= cfg_cmd_pkg::PGN_BASE_MAX
        || msg_byte(cmd_data, 2) == cfg_cmd_pkg::KEEP_BYTE;
    assign pop_ok = grid_ok && ((pop_req & ~FACTORY_POP[NUM_COMP-1:0]) == '0);
    assign delay_ok = delay_req <= cfg_cmd_pkg::DELAY_MS_MAX;
    assign known = cmd_pgn == cfg_cmd_pkg::PROP_A_PGN;

    // Reply frame built one cycle after the command is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsp_valid <= 1'b0;
            rsp_pgn <= 16'h0000;
            rsp_dest <= 8'h00;
            rsp_data <= 64'h0000_0000_0000_0000;
        end else if (take_cmd && known) begin
            rsp_pgn <= cfg_cmd_pkg::PROP_A_PGN;
            rsp_dest <= cmd_src;
            rsp_valid <= 1'b1;
            case (id_b)
                cfg_cmd_pkg::ID_SETTINGS: rsp_data <= {pgn_base_q, 24'h00_0000, sa_base_q, 5'h00, sa_offset, 8'h00,
                        cfg_cmd_pkg::ID_SETTINGS};
                cfg_cmd_pkg::ID_SET_BASES: rsp_data <= ack_frame(id_b, base_ok);
                cfg_cmd_pkg::ID_POP_QUERY: begin
                    if (grid_ok) begin
                        rsp_data <= {48'(pop_q), cfg_cmd_pkg::GRID_ADDR_ONLY, cfg_cmd_pkg::ID_POP_SET};
                    end else begin
                        rsp_data <= ack_frame(id_b, 1'b0);
                    end
                end
                cfg_cmd_pkg::ID_POP_SET: rsp_data <= ack_frame(id_b, pop_ok);
                cfg_cmd_pkg::ID_DEF_SET: rsp_data <= ack_frame(id_b, grid_ok);
                cfg_cmd_pkg::ID_DEF_QUERY: begin
                    if (grid_ok) begin
                        rsp_data <= {delay_ms_q, 16'(def_relay_q), 16'(relay_state), cfg_cmd_pkg::GRID_ADDR_ONLY,
                            cfg_cmd_pkg::ID_DEF_QUERY};
                    end else begin
                        rsp_data <= ack_frame(id_b, 1'b0);
                    end
                end
                cfg_cmd_pkg::ID_DELAY_SET: rsp_data <= ack_frame(id_b, delay_ok);
                default: rsp_valid <= 1'b0; // Commands handled elsewhere get no reply here
            endcase
        end else if (rsp_valid && rsp_ready) begin
            rsp_valid <= 1'b0;
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic wr_go;
    logic [7:0] wr_addr;
    logic [31:0] wmask;

    // Address and data are taken together so no skid storage is needed
    assign s_axil_awready = s_axil_awvalid && s_axil_wvalid && !s_axil_bvalid;
    assign s_axil_wready = s_axil_awready;
    assign wr_go = s_axil_awready;
    assign wr_addr = s_axil_awaddr;
    assign wmask = {{8{s_axil_wstrb[3]}}, {8{s_axil_wstrb[2]}}, {8{s_axil_wstrb[1]}}, {8{s_axil_wstrb[0]}}};

    function automatic logic [31:0] merged(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        merged = (old & ~m) | (nw & m);
    endfunction : merged

    function automatic logic mapped(input logic [7:0] a);
        mapped = a == cfg_cmd_pkg::REG_PGN_BASE || a == cfg_cmd_pkg::REG_SA_BASE
            || a == cfg_cmd_pkg::REG_DELAY || a == cfg_cmd_pkg::REG_POP_LO
            || a == cfg_cmd_pkg::REG_POP_HI || a == cfg_cmd_pkg::REG_DEF_RELAY
            || a == cfg_cmd_pkg::REG_STATUS || a == cfg_cmd_pkg::REG_MISSING_LO
            || a == cfg_cmd_pkg::REG_MISSING_HI;
    endfunction : mapped

    logic [31:0] wr_val;
    logic [63:0] pop_wide;
    assign pop_wide = 64'(pop_q);

    always_comb begin
        wr_val = 32'h0000_0000;
        case (wr_addr)
            cfg_cmd_pkg::REG_PGN_BASE: wr_val = merged(32'(pgn_base_q), s_axil_wdata, wmask);
            cfg_cmd_pkg::REG_SA_BASE: wr_val = merged(32'(sa_base_q), s_axil_wdata, wmask);
            cfg_cmd_pkg::REG_DELAY: wr_val = merged(32'(delay_ms_q), s_axil_wdata, wmask);
            cfg_cmd_pkg::REG_POP_LO: wr_val = merged(pop_wide[31:0], s_axil_wdata, wmask);
            cfg_cmd_pkg::REG_POP_HI: wr_val = merged(pop_wide[63:32], s_axil_wdata, wmask);
            cfg_cmd_pkg::REG_DEF_RELAY: wr_val = merged(32'(def_relay_q), s_axil_wdata, wmask);
            default: wr_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= cfg_cmd_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axil_bvalid <= 1'b1;
            s_axil_bresp <= mapped(wr_addr) ? cfg_cmd_pkg::RESP_OKAY : cfg_cmd_pkg::RESP_SLVERR;
        end else if (s_axil_bready) begin
            s_axil_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // Settings updates (bus and commands)
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pgn_base_q <= cfg_cmd_pkg::PGN_BASE_RESET;
            sa_base_q <= cfg_cmd_pkg::SA_BASE_RESET;
            delay_ms_q <= cfg_cmd_pkg::DELAY_MS_RESET;
            pop_q <= FACTORY_POP[NUM_COMP-1:0];
            def_relay_q <= {NUM_RELAY{cfg_cmd_pkg::RELAY_DEFAULT_RESET}};
        end else if (take_cmd && known) begin
            case (id_b)
                cfg_cmd_pkg::ID_SET_BASES: begin
                    if (msg_byte(cmd_data, 1) != cfg_cmd_pkg::KEEP_BYTE) begin
                        sa_base_q <= msg_byte(cmd_data, 1);
                    end
                    if (msg_byte(cmd_data, 2) <= cfg_cmd_pkg::PGN_BASE_MAX) begin
                        pgn_base_q <= msg_byte(cmd_data, 2);
                    end
                end
                cfg_cmd_pkg::ID_POP_SET: if (pop_ok) pop_q <= pop_req;
                cfg_cmd_pkg::ID_DEF_SET: if (grid_ok) def_relay_q <= def_req;
                cfg_cmd_pkg::ID_DELAY_SET: if (delay_ok) delay_ms_q <= delay_req;
                default: ;
            endcase
        end else if (wr_go) begin
            case (wr_addr)
                cfg_cmd_pkg::REG_PGN_BASE: begin
                    if (wr_val[7:0] <= cfg_cmd_pkg::PGN_BASE_MAX && wr_val[31:8] == 24'h00_0000) begin
                        pgn_base_q <= wr_val[7:0];
                    end
                end
                cfg_cmd_pkg::REG_SA_BASE: sa_base_q <= wr_val[7:0];
                cfg_cmd_pkg::REG_DELAY: begin
                    if (wr_val[15:0] <= cfg_cmd_pkg::DELAY_MS_MAX) begin
                        delay_ms_q <= wr_val[15:0];
                    end
                end
                cfg_cmd_pkg::REG_POP_LO: pop_q <= pop_q_from(pop_wide[63:32], wr_val);
                cfg_cmd_pkg::REG_POP_HI: pop_q <= pop_q_from(wr_val, pop_wide[31:0]);
                cfg_cmd_pkg::REG_DEF_RELAY: def_relay_q <= wr_val[NUM_RELAY-1:0];
                default: ;
            endcase
        end
    end

    // Bus writes to population also obey the factory mask
    function automatic logic [NUM_COMP-1:0] pop_q_from(input logic [31:0] hi, input logic [31:0] lo);
        logic [63:0] w;
        w = {hi, lo};
        pop_q_from = w[NUM_COMP-1:0] & FACTORY_POP[NUM_COMP-1:0];
    endfunction : pop_q_from

    // ****************************************
    // Command counter and read channel
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_cnt_q <= 16'h0000;
        end else if (take_cmd) begin
            cmd_cnt_q <= cmd_cnt_q + 16'h0001;
        end
    end

    logic [63:0] miss_wide;
    logic [31:0] rd_val;
    assign miss_wide = 64'(missing_comp);
    assign s_axil_arready = !s_axil_rvalid;

    always_comb begin
        rd_val = 32'h0000_0000;
        case (s_axil_araddr)
            cfg_cmd_pkg::REG_PGN_BASE: rd_val = 32'(pgn_base_q);
            cfg_cmd_pkg::REG_SA_BASE: rd_val = 32'(sa_base_q);
            cfg_cmd_pkg::REG_DELAY: rd_val = 32'(delay_ms_q);
            cfg_cmd_pkg::REG_POP_LO: rd_val = pop_wide[31:0];
            cfg_cmd_pkg::REG_POP_HI: rd_val = pop_wide[63:32];
            cfg_cmd_pkg::REG_DEF_RELAY: rd_val = 32'(def_relay_q);
            cfg_cmd_pkg::REG_STATUS: begin
                rd_val[cfg_cmd_pkg::STAT_READY_BIT] = started_q;
                rd_val[cfg_cmd_pkg::STAT_CMD_CNT_LSB +: 16] = cmd_cnt_q;
            end
            cfg_cmd_pkg::REG_MISSING_LO: rd_val = miss_wide[31:0];
            cfg_cmd_pkg::REG_MISSING_HI: rd_val = miss_wide[63:32];
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h0000_0000;
            s_axil_rresp <= cfg_cmd_pkg::RESP_OKAY;
        end else if (s_axil_arvalid && s_axil_arready) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rdata <= rd_val;
            s_axil_rresp <= mapped(s_axil_araddr) ? cfg_cmd_pkg::RESP_OKAY : cfg_cmd_pkg::RESP_SLVERR;
        end else if (s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
        end
    end
endmodule : cfg_cmd_handler

`default_nettype wire

// ==== bench/cfg_cmd_handler_assertions.sv ====
// Port checker for the configuration command handler
`timescale 1ns/1ns
`default_nettype none
module cfg_cmd_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [15:0] cmd_pgn,
    input wire logic [7:0] cmd_src,
    input wire logic [63:0] cmd_data,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [15:0] rsp_pgn,
    input wire logic [7:0] rsp_dest,
    input wire logic [63:0] rsp_data,
    input wire logic count_breach,
    input wire logic [15:0] fuse_status_pgn,
    input wire logic [15:0] error_status_pgn,
    input wire logic relay_apply,
    input wire logic link_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic q97 = cmd_valid && cmd_ready && cmd_pgn == 16'hEF00 && cmd_data[7:0] == 8'h97;
    property p_upper; fuse_status_pgn[15:8] == 8'hFF && error_status_pgn[15:8] == 8'hFF; endproperty
    a_upper: assert property (p_upper) else $error("status group upper byte wrong");
    property p_offs; error_status_pgn[7:0] == fuse_status_pgn[7:0] + 8'h02; endproperty
    a_offs: assert property (p_offs) else $error("status group offset wrong");
    property p_range; fuse_status_pgn[7:0] <= 8'hF1; endproperty
    a_range: assert property (p_range) else $error("status base out of range");
    property p_quiet; !link_enable |-> !cmd_ready && !rsp_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("active during start-up delay");
    property p_frame; rsp_valid |-> rsp_pgn == 16'hEF00; endproperty
    a_frame: assert property (p_frame) else $error("reply group number wrong");
    property p_dest; q97 |=> rsp_valid && rsp_dest == $past(cmd_src)
        && {8'hFF, rsp_data[63:56]} == $past(fuse_status_pgn); endproperty
    a_dest: assert property (p_dest) else $error("settings reply wrong");
    property p_hold; rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data); endproperty
    a_hold: assert property (p_hold) else $error("reply dropped before taken");
    property p_apply; count_breach |=> relay_apply; endproperty
    a_apply: assert property (p_apply) else $error("defaults not applied on breach");
endmodule : cfg_cmd_checker
bind cfg_cmd_handler cfg_cmd_checker i_cfg_cmd_checker (.aclk(aclk), .aresetn(aresetn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_pgn(cmd_pgn), .cmd_src(cmd_src),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_pgn(rsp_pgn),
    .rsp_dest(rsp_dest), .rsp_data(rsp_data), .count_breach(count_breach),
    .fuse_status_pgn(fuse_status_pgn), .error_status_pgn(error_status_pgn),
    .relay_apply(relay_apply), .link_enable(link_enable));
`default_nettype wire

// ==== bench/cfg_ctrl_model.sv ====
// Bus controller model that sends commands and takes replies
`timescale 1ns/1ns
`default_nettype none
module cfg_ctrl_model (
    input wire logic aclk,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_dest,
    input wire logic [63:0] rsp_data,
    output logic cmd_valid,
    output logic [15:0] cmd_pgn,
    output logic [7:0] cmd_src,
    output logic [63:0] cmd_data,
    output logic rsp_ready
);
    initial begin
        cmd_valid = 1'b0;
        cmd_pgn = 16'h0000;
        cmd_src = 8'h00;
        cmd_data = 64'h0;
        rsp_ready = 1'b0;
    end
    // Slow controller: rsp_ready held low for stall cycles
    task automatic xfer(input logic [63:0] d, input logic [7:0] src, input int stall,
                        output logic [63:0] r, output logic [7:0] dst);
        @(posedge aclk);
        cmd_valid <= 1'b1;
        cmd_pgn <= 16'hEF00;
        cmd_src <= src;
        cmd_data <= d;
        do @(posedge aclk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        // Released lines show the inverse, never a stale copy
        cmd_pgn <= 16'h10FF;
        cmd_src <= ~src;
        cmd_data <= ~d;
        repeat (stall) @(posedge aclk);
        rsp_ready <= 1'b1;
        do @(posedge aclk); while (rsp_valid !== 1'b1);
        r = rsp_data;
        dst = rsp_dest;
        rsp_ready <= 1'b0;
    endtask : xfer
endmodule : cfg_ctrl_model
`default_nettype wire

// ==== bench/can_config_command_handler_tb_top.sv ====
// Testbench for the configuration command handler
`timescale 1ns/1ns
`default_nettype none
module can_config_command_handler_tb_top;
    localparam int CPM = 2;
    logic aclk = 1'b0, aresetn = 1'b0, count_breach = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, cmd_src, rsp_dest, dst;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [1:0] bresp, rresp, resp;
    logic awready, wready, bvalid, arready, rvalid, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
    logic relay_apply, link_enable;
    logic [15:0] cmd_pgn, rsp_pgn, fpgn, rpgn, epgn;
    logic [63:0] cmd_data, rsp_data, r;
    logic [47:0] missing;
    logic [12:0] rdef;
    int mismatches = 0, n_checks = 0, n;
    // ****************************************
    // Command table: command, expected reply
    // ****************************************
    logic [63:0] rows [15][2] = '{
        '{64'h97, 64'hA000_0000_B005_0097}, '{64'hF1_FF90, 64'h01_9001}, '{64'hF2_FF90, 64'h9001},
        '{64'h97, 64'hF100_0000_B005_0097}, '{64'h92, 64'h00FF_FFFF_FFFF_0094},
        '{64'h8000_0000_0000_0094, 64'h9401}, '{64'h000F_0094, 64'h01_9401}, '{64'h0192, 64'h9201},
        '{64'h92, 64'h000F_0094}, '{64'h1ABC_0095, 64'h01_9501}, '{64'h96, 64'h03E8_1ABC_0123_0096},
        '{64'h0296, 64'h9601}, '{64'hFF_FF99, 64'h9901}, '{64'h0599, 64'h01_9901},
        '{64'h96, 64'h0005_1ABC_0123_0096}};
    cfg_cmd_handler #(.FACTORY_POP(48'h00FF_FFFF_FFFF), .CYCLES_PER_MS(CPM)) i_cfg_cmd_handler (
        .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
        .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
        .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_pgn(cmd_pgn), .cmd_src(cmd_src),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_pgn(rsp_pgn),
        .rsp_dest(rsp_dest), .rsp_data(rsp_data), .sa_offset(3'd5), .comp_present(48'hFFFF_FFFF_FFF5),
        .relay_state(13'h0123), .count_breach(count_breach), .fuse_status_pgn(fpgn),
        .relay_status_pgn(rpgn), .error_status_pgn(epgn), .missing_comp(missing),
        .relay_default(rdef), .relay_apply(relay_apply), .link_enable(link_enable));
    cfg_ctrl_model i_cfg_ctrl_model (.aclk(aclk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_dest(rsp_dest), .rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd_pgn(cmd_pgn),
        .cmd_src(cmd_src), .cmd_data(cmd_data), .rsp_ready(rsp_ready));
    always #4 aclk = ~aclk;
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rd
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        check("relay_apply", relay_apply, 1);
        check("status pgns", {fpgn, rpgn, epgn}, 48'hFFA0_FFA1_FFA2);
        check("relay_default", rdef, 0);
        n = 0;
        while (link_enable !== 1'b1 && n < 3000) begin
            @(posedge aclk);
            #1;
            n++;
        end
        check("start delay", n, 1000 * CPM + 1);
        $display("reset test done");
        for (int i = 0; i < 15; i++) begin
            i_cfg_ctrl_model.xfer(rows[i][0], 8'h20 + 8'(i), i % 3, r, dst);
            check("reply", r, rows[i][1]);
            check("reply dest", dst, 8'h20 + 8'(i));
        end
        check("pgns", {fpgn, epgn}, 32'hFFF1_FFF3);
        check("missing", missing, 48'h0000_0000_000A);
        check("defaults", rdef, 13'h1ABC);
        $display("command table done");
        wr(8'h00, 32'h0000_00F5, resp);
        rd(8'h00, rv, resp);
        check("base kept", {resp, rv}, {2'b00, 32'h0000_00F1});
        wr(8'h00, 32'h0000_0010, resp);
        check("fuse pgn", fpgn, 16'hFF10);
        rd(8'h40, rv, resp);
        check("unmapped", resp, 2'b10);
        rd(8'h18, rv, resp);
        check("link bit", rv[0], 1);
        check("apply idle", relay_apply, 0);
        @(posedge aclk);
        count_breach <= 1'b1;
        @(posedge aclk);
        count_breach <= 1'b0;
        #1;
        check("breach apply", relay_apply, 1);
        $display("register test done");
        stop_test();
    end
endmodule : can_config_command_handler_tb_top
`default_nettype wire
